// >>> dtfc_consts.vh
// Register offsets, field positions, action encodings, reset values and counter limits of the dual timer flag block.
`ifndef DTFC_CONSTS_VH
`define DTFC_CONSTS_VH

// Register offsets on the plain register port.
`define DTFC_ADDR_W          4
`define DTFC_OFS_X_STATUS    4'h0
`define DTFC_OFS_Y_STATUS    4'h1
`define DTFC_OFS_CAP_RISE    4'h2
`define DTFC_OFS_CAP_FALL    4'h3
`define DTFC_OFS_OFFSET_CMP  4'h5
`define DTFC_OFS_CAP_CTRL    4'h8

// Status register field positions and the capture control start bit.
`define DTFC_BIT_MATCH_B     7
`define DTFC_BIT_MATCH_A     6
`define DTFC_BIT_WRAP        5
`define DTFC_BIT_CAPTURE     4
`define DTFC_BIT_B_ACT_HI    3
`define DTFC_BIT_B_ACT_LO    2
`define DTFC_BIT_A_ACT_HI    1
`define DTFC_BIT_A_ACT_LO    0
`define DTFC_BIT_CAP_START   4

// Output action encodings.
`define DTFC_ACT_KEEP        2'h0
`define DTFC_ACT_LOW         2'h1
`define DTFC_ACT_HIGH        2'h2
`define DTFC_ACT_TOGGLE      2'h3

// Reset values and counter limits.
`define DTFC_RST_OFFSET_CMP  8'hFF
`define DTFC_RST_CAPTURE     8'h00
`define DTFC_RST_STATUS      8'h00
`define DTFC_CNT_MAX         8'hFF
`define DTFC_CNT_MIN         8'h00

`endif

// >>> dtfc_top.v
// Flag, output-select, offset-compare and pulse-capture logic for timer channels X and Y.
//
// Summary of operation
// - X match-B flag is bit 7, X match-A flag is bit 6.
// - Y match-B flag is bit 7, Y match-A flag is bit 6.
// - X wrap flag, bit 5, sets when counter X goes FF to 00.
// - Y wrap flag, bit 5, sets when counter Y goes FF to 00.
// - Match and wrap flags clear by read-as-one then write zero; reset zero.
// - X status bit 4 sets after rising then falling external reset edge.
// - Capture flag clears by read-as-one then write zero; reset zero.
// - Y status bit 4 enables the capture interrupt request.
// - Action 00 keeps, 01 drives low, 10 drives high, 11 toggles.
// - X bits 3:2 act on match B, bits 1:0 on match A.
// - Y bits 3:2 act on match B, bits 1:0 on match A.
// - Match C fires when counter equals offset compare plus captured value.
// - Match C is suppressed during offset compare writes and capture cycles.
// - Offset compare is read-write and resets to FF.
// - With start set, capture counter on rising then next falling edge.
// - Start bit clears itself after one full capture operation.
// - Both capture registers are read-only and reset to 00.
// - Start bit sets only by writing one after reading it as zero.
`include "dtfc_consts.vh"
`default_nettype none

module dtfc_top #(
    parameter CNT_W = 8
) (
    input  wire             mclk_i,
    input  wire             rst_i,
    input  wire [3:0]       reg_addr_i,
    input  wire [7:0]       reg_wdata_i,
    input  wire             reg_wr_i,
    input  wire             reg_rd_i,
    output reg  [7:0]       reg_rdata_o,
    input  wire [CNT_W-1:0] chan_x_counter_i,
    input  wire [CNT_W-1:0] chan_y_counter_i,
    input  wire [CNT_W-1:0] chan_x_compare_a_i,
    input  wire [CNT_W-1:0] chan_x_compare_b_i,
    input  wire [CNT_W-1:0] chan_y_compare_a_i,
    input  wire [CNT_W-1:0] chan_y_compare_b_i,
    input  wire             external_reset_in_i,
    output reg              chan_x_compare_out_o,
    output reg              chan_y_compare_out_o,
    output reg              match_c_o,
    output wire             capture_irq_o
);

    // Capture sequencer states.
    localparam [1:0] ST_IDLE      = 2'h0;
    localparam [1:0] ST_WAIT_RISE = 2'h1;
    localparam [1:0] ST_WAIT_FALL = 2'h2;

    // Applies a two-bit action code to the present pin level.
    function apply_action;
        input [1:0] act;
        input       cur;
        begin
            case (act)
                `DTFC_ACT_KEEP:   apply_action = cur;
                `DTFC_ACT_LOW:    apply_action = 1'b0;
                `DTFC_ACT_HIGH:   apply_action = 1'b1;
                `DTFC_ACT_TOGGLE: apply_action = ~cur;
                default:          apply_action = cur;
            endcase
        end
    endfunction

    // Next value of a sticky flag: a set beats a clearing write.
    function flag_next;
        input cur;
        input set;
        input armed;
        input wr_hit;
        input wbit;
        begin
            if (set) begin
                flag_next = 1'b1;
            end else if (wr_hit && armed && !wbit) begin
                flag_next = 1'b0;
            end else begin
                flag_next = cur;
            end
        end
    endfunction

    // Decodes one register strobe against one register offset.
    function strobe_at;
        input       strobe;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            strobe_at = strobe && (addr == ofs);
        end
    endfunction

    // A compare event: the counter has just stepped onto the compare value.
    function step_hit;
        input [CNT_W-1:0] cur;
        input [CNT_W-1:0] prev;
        input [CNT_W-1:0] cmp;
        begin
            step_hit = (cur != prev) && (cur == cmp);
        end
    endfunction

    // A wrap: the previous sample sat at the maximum and the counter now sits at the minimum.
    function wrapped;
        input [CNT_W-1:0] cur;
        input [CNT_W-1:0] prev;
        begin
            wrapped = (prev == `DTFC_CNT_MAX) && (cur == `DTFC_CNT_MIN);
        end
    endfunction

    // Registers and state.
    reg [7:0]       x_status_q;
    reg [7:0]       x_status_d;
    reg [7:0]       y_status_q;
    reg [7:0]       y_status_d;
    reg [3:0]       x_arm_q;
    reg [3:0]       x_arm_d;
    reg [2:0]       y_arm_q;
    reg [2:0]       y_arm_d;
    reg [7:0]       offset_cmp_q;
    reg [7:0]       cap_rise_q;
    reg [7:0]       cap_fall_q;
    reg             cap_start_q;
    reg             cap_start_d;
    reg             start_arm_q;
    reg             start_arm_d;
    reg [1:0]       cap_st_q;
    reg [1:0]       cap_st_d;
    reg             ext_prev_q;
    reg [CNT_W-1:0] x_prev_q;
    reg [CNT_W-1:0] y_prev_q;

    // Decoded register port strobes.
    wire wr_x   = strobe_at(reg_wr_i, reg_addr_i, `DTFC_OFS_X_STATUS);
    wire wr_y   = strobe_at(reg_wr_i, reg_addr_i, `DTFC_OFS_Y_STATUS);
    wire wr_ofs = strobe_at(reg_wr_i, reg_addr_i, `DTFC_OFS_OFFSET_CMP);
    wire wr_cc  = strobe_at(reg_wr_i, reg_addr_i, `DTFC_OFS_CAP_CTRL);
    wire rd_x   = strobe_at(reg_rd_i, reg_addr_i, `DTFC_OFS_X_STATUS);
    wire rd_y   = strobe_at(reg_rd_i, reg_addr_i, `DTFC_OFS_Y_STATUS);
    wire rd_cc  = strobe_at(reg_rd_i, reg_addr_i, `DTFC_OFS_CAP_CTRL);

    // Counters arrive from the counting logic; an event counts once, when the counter
    // has just moved onto the value, so a stopped counter does not retoggle the pins.
    wire x_hit_a = step_hit(chan_x_counter_i, x_prev_q, chan_x_compare_a_i);
    wire x_hit_b = step_hit(chan_x_counter_i, x_prev_q, chan_x_compare_b_i);
    wire y_hit_a = step_hit(chan_y_counter_i, y_prev_q, chan_y_compare_a_i);
    wire y_hit_b = step_hit(chan_y_counter_i, y_prev_q, chan_y_compare_b_i);

    // Wrap is seen as the maximum followed by the minimum.
    wire x_wrap = wrapped(chan_x_counter_i, x_prev_q);
    wire y_wrap = wrapped(chan_y_counter_i, y_prev_q);

    // Edges of the external reset input, taken as synchronous.
    wire ext_rise = external_reset_in_i && !ext_prev_q;
    wire ext_fall = !external_reset_in_i && ext_prev_q;

    // Capture events of this cycle.
    wire take_rise = (cap_st_q == ST_WAIT_RISE) && ext_rise;
    wire take_fall = (cap_st_q == ST_WAIT_FALL) && ext_fall;
    wire cap_done  = take_fall;

    // Offset compare sum wraps in eight bits, as the counter does.
    wire [7:0] match_c_ref = offset_cmp_q + cap_rise_q;

    // Capture sequencer: waits for a rising edge, then the next falling edge.
    // Edges seen before the sequencer has left idle are ignored, so the write cycle
    // that sets the start bit and the cycle after it cannot begin a capture.
    always @* begin
        cap_st_d = cap_st_q;
        case (cap_st_q)
            ST_IDLE: begin
                if (cap_start_q) begin
                    cap_st_d = ST_WAIT_RISE;
                end
            end
            ST_WAIT_RISE: begin
                if (take_rise) begin
                    cap_st_d = ST_WAIT_FALL;
                end
            end
            ST_WAIT_FALL: begin
                if (take_fall) begin
                    cap_st_d = ST_IDLE;
                end
            end
            default: begin
                cap_st_d = ST_IDLE;
            end
        endcase
    end

    // Start bit: set only by a write of one that follows a read of zero.
    // The end of a capture wins over a setting write in the same cycle, so software
    // that races the falling edge has to read and start again.
    always @* begin
        cap_start_d = cap_start_q;
        start_arm_d = start_arm_q;
        if (cap_done) begin
            cap_start_d = 1'b0;
        end else if (wr_cc && start_arm_q && reg_wdata_i[`DTFC_BIT_CAP_START]) begin
            cap_start_d = 1'b1;
        end
        if (rd_cc) begin
            start_arm_d = !cap_start_q;
        end else if (wr_cc) begin
            start_arm_d = 1'b0;
        end
    end

    // Channel X status: flags in 7:4, action fields in 3:0.
    // Every flag goes through flag_next, so the set-beats-clear order lives in
    // one place for all seven flags of both channels.
    always @* begin
        x_status_d = x_status_q;
        x_status_d[`DTFC_BIT_MATCH_B] = flag_next(x_status_q[`DTFC_BIT_MATCH_B], x_hit_b,
            x_arm_q[3], wr_x, reg_wdata_i[`DTFC_BIT_MATCH_B]);
        x_status_d[`DTFC_BIT_MATCH_A] = flag_next(x_status_q[`DTFC_BIT_MATCH_A], x_hit_a,
            x_arm_q[2], wr_x, reg_wdata_i[`DTFC_BIT_MATCH_A]);
        x_status_d[`DTFC_BIT_WRAP] = flag_next(x_status_q[`DTFC_BIT_WRAP], x_wrap,
            x_arm_q[1], wr_x, reg_wdata_i[`DTFC_BIT_WRAP]);
        x_status_d[`DTFC_BIT_CAPTURE] = flag_next(x_status_q[`DTFC_BIT_CAPTURE], cap_done,
            x_arm_q[0], wr_x, reg_wdata_i[`DTFC_BIT_CAPTURE]);
        if (wr_x) begin
            x_status_d[3:0] = reg_wdata_i[3:0];
        end
    end

    // Channel Y status: flags in 7:5, capture enable in 4, action fields in 3:0.
    // The capture enable and the action fields are plain storage with no arming.
    always @* begin
        y_status_d = y_status_q;
        y_status_d[`DTFC_BIT_MATCH_B] = flag_next(y_status_q[`DTFC_BIT_MATCH_B], y_hit_b,
            y_arm_q[2], wr_y, reg_wdata_i[`DTFC_BIT_MATCH_B]);
        y_status_d[`DTFC_BIT_MATCH_A] = flag_next(y_status_q[`DTFC_BIT_MATCH_A], y_hit_a,
            y_arm_q[1], wr_y, reg_wdata_i[`DTFC_BIT_MATCH_A]);
        y_status_d[`DTFC_BIT_WRAP] = flag_next(y_status_q[`DTFC_BIT_WRAP], y_wrap,
            y_arm_q[0], wr_y, reg_wdata_i[`DTFC_BIT_WRAP]);
        if (wr_y) begin
            y_status_d[4:0] = reg_wdata_i[4:0];
        end
    end

    // Clear arms: a read records which flags were one; any write to the register
    // uses them up, so a second write without a fresh read clears nothing.
    always @* begin
        x_arm_d = x_arm_q;
        y_arm_d = y_arm_q;
        if (rd_x) begin
            x_arm_d = x_status_q[7:4];
        end else if (wr_x) begin
            x_arm_d = 4'h0;
        end
        if (rd_y) begin
            y_arm_d = y_status_q[7:5];
        end else if (wr_y) begin
            y_arm_d = 3'h0;
        end
    end

    // State registers. The previous samples reset to zero, the idle level of the
    // external reset input, so no false rising edge is seen just after a reset.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            x_status_q  <= `DTFC_RST_STATUS;
            y_status_q  <= `DTFC_RST_STATUS;
            x_arm_q     <= 4'h0;
            y_arm_q     <= 3'h0;
            cap_start_q <= 1'b0;
            start_arm_q <= 1'b0;
            cap_st_q    <= ST_IDLE;
            ext_prev_q  <= 1'b0;
            x_prev_q    <= {CNT_W{1'b0}};
            y_prev_q    <= {CNT_W{1'b0}};
        end else begin
            x_status_q  <= x_status_d;
            y_status_q  <= y_status_d;
            x_arm_q     <= x_arm_d;
            y_arm_q     <= y_arm_d;
            cap_start_q <= cap_start_d;
            start_arm_q <= start_arm_d;
            cap_st_q    <= cap_st_d;
            ext_prev_q  <= external_reset_in_i;
            x_prev_q    <= chan_x_counter_i;
            y_prev_q    <= chan_y_counter_i;
        end
    end

    // Offset compare register and the two capture registers.
    // Writes to the capture offsets match no write decode, which keeps both
    // capture registers read-only without any extra logic.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            offset_cmp_q <= `DTFC_RST_OFFSET_CMP;
            cap_rise_q   <= `DTFC_RST_CAPTURE;
            cap_fall_q   <= `DTFC_RST_CAPTURE;
        end else begin
            if (wr_ofs) begin
                offset_cmp_q <= reg_wdata_i;
            end
            if (take_rise) begin
                cap_rise_q <= chan_x_counter_i[7:0];
            end
            if (take_fall) begin
                cap_fall_q <= chan_x_counter_i[7:0];
            end
        end
    end

    // Compare outputs; when both matches land together, only the B action is applied.
    // An A action is lost in that cycle, so the two compare values should differ.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            chan_x_compare_out_o <= 1'b0;
            chan_y_compare_out_o <= 1'b0;
        end else begin
            if (x_hit_b) begin
                chan_x_compare_out_o <= apply_action(x_status_q[3:2], chan_x_compare_out_o);
            end else if (x_hit_a) begin
                chan_x_compare_out_o <= apply_action(x_status_q[1:0], chan_x_compare_out_o);
            end
            if (y_hit_b) begin
                chan_y_compare_out_o <= apply_action(y_status_q[3:2], chan_y_compare_out_o);
            end else if (y_hit_a) begin
                chan_y_compare_out_o <= apply_action(y_status_q[1:0], chan_y_compare_out_o);
            end
        end
    end

    // Match C is a level, registered; the sum may be stale while it changes, hence the blanking.
    // It is one cycle late against the counter value it was computed from.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            match_c_o <= 1'b0;
        end else begin
            match_c_o <= (chan_x_counter_i[7:0] == match_c_ref) && !wr_ofs && !take_rise
                && !take_fall;
        end
    end

    // Capture request follows the flag and its enable.
    // It is combinational from two flip-flops, so it needs no settling of its own.
    assign capture_irq_o = x_status_q[`DTFC_BIT_CAPTURE] && y_status_q[`DTFC_BIT_CAPTURE];

    // Register read port: data stand in the cycle after the read strobe only.
    // Zero at all other times lets several blocks share an or-ed read bus; the
    // flags shown are those of the strobe cycle, which the arming logic relies on.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DTFC_OFS_X_STATUS:   reg_rdata_o <= x_status_q;
                `DTFC_OFS_Y_STATUS:   reg_rdata_o <= y_status_q;
                `DTFC_OFS_CAP_RISE:   reg_rdata_o <= cap_rise_q;
                `DTFC_OFS_CAP_FALL:   reg_rdata_o <= cap_fall_q;
                `DTFC_OFS_OFFSET_CMP: reg_rdata_o <= offset_cmp_q;
                `DTFC_OFS_CAP_CTRL:   reg_rdata_o <= {3'h0, cap_start_q, 4'h0};
                default:              reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule

`default_nettype wire

// >>> dtfc_top_properties.sv
// Port-level assertions for the dual timer flag block, bound to its top module.
`include "dtfc_consts.vh"
`default_nettype none
module dtfc_top_properties #(
    parameter CNT_W = 8
) (
    input wire logic             mclk_i,
    input wire logic             rst_i,
    input wire logic [3:0]       reg_addr_i,
    input wire logic [7:0]       reg_wdata_i,
    input wire logic             reg_wr_i,
    input wire logic             reg_rd_i,
    input wire logic [7:0]       reg_rdata_o,
    input wire logic [CNT_W-1:0] chan_x_counter_i,
    input wire logic [CNT_W-1:0] chan_y_counter_i,
    input wire logic [CNT_W-1:0] chan_x_compare_a_i,
    input wire logic [CNT_W-1:0] chan_x_compare_b_i,
    input wire logic [CNT_W-1:0] chan_y_compare_a_i,
    input wire logic [CNT_W-1:0] chan_y_compare_b_i,
    input wire logic             external_reset_in_i,
    input wire logic             chan_x_compare_out_o,
    input wire logic             chan_y_compare_out_o,
    input wire logic             match_c_o,
    input wire logic             capture_irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CNT_W-1:0] px_q;
    logic [CNT_W-1:0] py_q;
    logic [CNT_W-1:0] ofs_q;
    logic             cap_q;
    wire logic        wr_y = reg_wr_i && reg_addr_i == `DTFC_OFS_Y_STATUS;
    wire logic        wr_o = reg_wr_i && reg_addr_i == `DTFC_OFS_OFFSET_CMP;
    wire logic        eq_c = chan_x_counter_i == ofs_q;
    // A pin may only move when its counter has just stepped onto one of its compare values.
    wire logic        hit_x = chan_x_counter_i != px_q &&
                              (chan_x_counter_i == chan_x_compare_a_i || chan_x_counter_i == chan_x_compare_b_i);
    wire logic        hit_y = chan_y_counter_i != py_q &&
                              (chan_y_counter_i == chan_y_compare_a_i || chan_y_counter_i == chan_y_compare_b_i);

    // Previous counter samples; no reset needed since every check is disabled while in reset.
    always @(posedge mclk_i) begin
        px_q <= chan_x_counter_i;
        py_q <= chan_y_counter_i;
    end

    // Shadow of the offset register; match C is only predicted until a capture could have been armed.
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ofs_q <= `DTFC_RST_OFFSET_CMP;
            cap_q <= 1'b0;
        end else begin
            if (wr_o) begin
                ofs_q <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == `DTFC_OFS_CAP_CTRL) begin
                cap_q <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_rdata_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
    property p_ofs_read;
        reg_rd_i && reg_addr_i == `DTFC_OFS_OFFSET_CMP |=> reg_rdata_o == $past(ofs_q);
    endproperty
    a_ofs_read: assert property (p_ofs_read) else $error("offset compare readback wrong");
    property p_cap_ro;
        reg_rd_i && !cap_q && (reg_addr_i == 4'h2 || reg_addr_i == 4'h3) |=> reg_rdata_o == 8'h00;
    endproperty
    a_cap_ro: assert property (p_cap_ro) else $error("capture register changed without capture");
    property p_ofs_quiet;
        wr_o |=> !match_c_o;
    endproperty
    a_ofs_quiet: assert property (p_ofs_quiet) else $error("match C during offset write");
    property p_match_c;
        !cap_q && !wr_o |=> match_c_o == $past(eq_c);
    endproperty
    a_match_c: assert property (p_match_c) else $error("match C wrong");
    property p_pin_x;
        $changed(chan_x_compare_out_o) |-> $past(hit_x);
    endproperty
    a_pin_x: assert property (p_pin_x) else $error("X pin moved without match");
    property p_pin_y;
        $changed(chan_y_compare_out_o) |-> $past(hit_y);
    endproperty
    a_pin_y: assert property (p_pin_y) else $error("Y pin moved without match");
    property p_irq_rise;
        $rose(capture_irq_o) |-> $past(wr_y) || ($past(external_reset_in_i, 2) && !$past(external_reset_in_i));
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("capture request rose without cause");
    property p_irq_fall;
        $fell(capture_irq_o) |-> $past(reg_wr_i);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("capture request fell without write");
endmodule
bind dtfc_top dtfc_top_properties #(.CNT_W(CNT_W)) u_props (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .chan_x_counter_i, .chan_y_counter_i, .chan_x_compare_a_i,
    .chan_x_compare_b_i, .chan_y_compare_a_i, .chan_y_compare_b_i, .external_reset_in_i,
    .chan_x_compare_out_o, .chan_y_compare_out_o, .match_c_o, .capture_irq_o);
`default_nettype wire

// >>> dtfc_top_tb.sv
// Self-checking bench for the dual timer flag block.
`default_nettype none
module dtfc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} dtfc_row_t;
    logic       mclk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] cx = 8'h00;
    logic [7:0] cy = 8'h00;
    logic       ext = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       px, py, mc, irq;
    logic [1:0] ex = 2'h0;
    int         n_mismatch = 0;
    int         num_checks = 0;
    // First six rows are reset values, the rest write then read back.
    dtfc_row_t  rows [13] = '{'{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h00}, '{1'b0, 4'h5, 8'h00, 8'hFF},
        '{1'b0, 4'h2, 8'h00, 8'h00}, '{1'b0, 4'h3, 8'h00, 8'h00}, '{1'b0, 4'h8, 8'h00, 8'h00},
        '{1'b1, 4'h0, 8'h0F, 8'h0F}, '{1'b1, 4'h1, 8'h1F, 8'h1F}, '{1'b1, 4'h5, 8'h5A, 8'h5A},
        '{1'b1, 4'h2, 8'hAA, 8'h00}, '{1'b1, 4'h3, 8'h55, 8'h00}, '{1'b1, 4'h7, 8'h33, 8'h00},
        '{1'b1, 4'h8, 8'hEF, 8'h00}};
    logic [1:0] acts [6] = '{2'h2, 2'h3, 2'h3, 2'h1, 2'h2, 2'h0};

    dtfc_top dut_u (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .chan_x_counter_i(cx), .chan_y_counter_i(cy), .chan_x_compare_a_i(8'h10), .chan_x_compare_b_i(8'h20),
        .chan_y_compare_a_i(8'h30), .chan_y_compare_b_i(8'h40), .external_reset_in_i(ext),
        .chan_x_compare_out_o(px), .chan_y_compare_out_o(py), .match_c_o(mc), .capture_irq_o(irq));

    always #2.5 mclk_i = ~mclk_i;

    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so they are sampled just after that edge.
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge mclk_i);
        reg_rd_i <= 1'b0;
        #1 chk(e, reg_rdata_o);
    endtask
    // Counters are held long enough for the registered flag, pin and match C to settle.
    task automatic cnt(input logic y, input logic [7:0] v);
        @(posedge mclk_i);
        if (y) cy <= v;
        else cx <= v;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        // X acts on match A in bits 1:0, Y on match B in bits 3:2; the model tracks both pins.
        foreach (acts[i]) begin
            wr(4'h0, {6'h00, acts[i]});
            wr(4'h1, {4'h1, acts[i], 2'h0});
            cnt(1'b0, 8'h10);
            cnt(1'b1, 8'h40);
            for (int c = 0; c < 2; c++) begin
                if (acts[i] == 2'h1) ex[c] = 1'b0;
                else if (acts[i] == 2'h2) ex[c] = 1'b1;
                else if (acts[i] == 2'h3) ex[c] = ~ex[c];
            end
            chk({6'h00, ex}, {6'h00, py, px});
            cnt(1'b0, 8'h11);
            cnt(1'b1, 8'h41);
        end
        cnt(1'b0, 8'h20);
        cnt(1'b1, 8'h30);
        cnt(1'b0, 8'hFF);
        cnt(1'b1, 8'hFF);
        cnt(1'b0, 8'h00);
        cnt(1'b1, 8'h00);
        chk({6'h00, ex}, {6'h00, py, px});
        wr(4'h0, 8'h00);
        rdc(4'h0, 8'hE0);
        rdc(4'h1, 8'hF0);
        wr(4'h0, 8'hFF);
        rdc(4'h0, 8'hEF);
        // A clearing write in the very cycle in which match A lands must leave that flag set.
        @(posedge mclk_i);
        cx <= 8'h10;
        reg_wr_i <= 1'b1;
        reg_addr_i <= 4'h0;
        reg_wdata_i <= 8'h00;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        #1;
        rdc(4'h0, 8'h40);
        wr(4'h0, 8'h00);
        rdc(4'h0, 8'h00);
        // One capture pulse: rise at counter 33, fall at counter 44.
        wr(4'h8, 8'h00);
        wr(4'h8, 8'h10);
        rdc(4'h8, 8'h00);
        wr(4'h8, 8'h10);
        rdc(4'h8, 8'h10);
        cnt(1'b0, 8'h33);
        ext <= 1'b1;
        cnt(1'b0, 8'h44);
        ext <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rdc(4'h2, 8'h33);
        rdc(4'h3, 8'h44);
        rdc(4'h8, 8'h00);
        rdc(4'h0, 8'h10);
        chk(8'h01, {7'h00, irq});
        cnt(1'b0, 8'h8D);
        chk(8'h01, {7'h00, mc});
        cnt(1'b0, 8'h8E);
        chk(8'h00, {7'h00, mc});
        wr(4'h1, 8'h00);
        chk(8'h00, {7'h00, irq});
        wr(4'h1, 8'h10);
        chk(8'h01, {7'h00, irq});
        wr(4'h0, 8'h10);
        wr(4'h0, 8'h00);
        chk(8'h01, {7'h00, irq});
        rdc(4'h0, 8'h10);
        wr(4'h0, 8'h00);
        chk(8'h00, {7'h00, irq});
        // A second reset in mid-run must bring back every reset value.
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 chk(8'h00, {6'h00, px, py});
        for (int i = 0; i < 6; i++) rdc(rows[i].a, rows[i].e);
        report_and_stop();
    end

    // The whole sequence needs well under ten thousand cycles.
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
